// ### core/cap_panel_regs.svh
// Register map, field positions and timing constants of the capacitor panel block.
// Assumes a 100 MHz pclk and word-aligned APB byte addresses.
`ifndef CAP_PANEL_REGS_SVH
`define CAP_PANEL_REGS_SVH
// Register byte offsets
`define OFF_CTRL       12'h000
`define OFF_DUR        12'h004
`define OFF_TRIP_DLY   12'h008
`define OFF_CLOSE_DLY  12'h00c
`define OFF_AFTER_TRIP 12'h010
`define OFF_STATUS     12'h014
`define OFF_COUNT      12'h018
// Control register fields
`define CTRL_AUTO_TRIP  0
`define CTRL_AUTO_CLOSE 1
`define CTRL_UV_INH     2
`define CTRL_HUNT_INH   3
`define CTRL_LIMIT_HIT  4
`define CTRL_REV_PWR    5
`define CTRL_LOCKOUT    6
// Duration code: zero means 0.3 s, else whole seconds
`define DUR_SHORT_CODE  8'h00
`define DUR_RESET       8'h01
`define DLY_RESET       16'h0000
`define AFTER_TRIP_RST  16'h012c
// Timing in milliseconds, cycles derived at 100 MHz
`define CLK_MHZ         100
`define SHORT_PULSE_MS  300
`define BLINK_MS        250
`define FAST_BLINK_MS   25
`define SCREEN_MS       5000
`define LAMP_TEST_MS    2000
`define MS_CYCLES       (`CLK_MHZ * 1000)
`define MS_PER_S        32'd1000
`define ZERO32          32'h0000_0000
`endif

// ### core/cap_panel_pkg.sv
// Types shared by the capacitor panel block.
// Assumes the constants header is included by the design file.
package cap_panel_pkg;
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_TRIP_WAIT  = 3'b001,
    ST_TRIP_PULSE = 3'b010,
    ST_CLS_WAIT   = 3'b011,
    ST_CLS_PULSE  = 3'b100
  } seq_state_e;
  typedef struct packed {
    logic ac_power;
    logic cpu_ok;
    logic rev_power;
    logic trip_inh;
    logic trip;
    logic close;
    logic close_inh;
    logic lockout;
    logic rx;
    logic tx;
  } lamps_s;
  typedef struct packed {
    logic auto_sel;
    logic trip_sw;
    logic close_sw;
    logic reset_sw;
    logic rx_act;
    logic tx_act;
  } panel_s;
endpackage : cap_panel_pkg

// ### core/cap_panel_ctrl.sv
// Manual trip/close sequencing, relay pulses and panel lamps of the capacitor controller.
// Assumes APB master on pclk; panel inputs are asynchronous and are synchronised here.
//
// Summary of operation
// - Trip/close switch is ignored unless the selector is in manual.
// - Manual suspends automatic commands; automatic lets them run.
// - Uninhibited manual trip pulses trip relay and lights trip lamp steadily.
// - Trip during inhibit flashes trip lamp, pends, then fires at expiry.
// - Each trip starts the close-after-trip timer which blocks closing.
// - Manual close while tripped and uninhibited pulses close relay, lights lamp.
// - Close during inhibit flashes close lamp, pends, fires after manual delay.
// - Trip/close lamps show the last command; flashing means pending.
// - Trip inhibit lamp lights during manual trip delay or undervoltage.
// - Close inhibit from after-trip, manual delay, undervoltage, anti-hunt, limit.
// - Processor healthy lamp toggles four times per second.
// - Reverse power lamp follows reverse power detection.
// - Receive/transmit lamps flash rapidly during port traffic.
// - At reset all lamps except receive/transmit light for a check.
// - Display screen index advances every five seconds.
// - Close counter advances once per close and is cleared only by reset.
// - Lockout lights its lamp, blocks automatic, clears on reset switch.
// - Relay duration is 0.3 s or 1 to 255 whole seconds.
// - Optical and serial traffic are treated alike.
`timescale 1ns/1ps
`include "cap_panel_regs.svh"

module cap_panel_ctrl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire cap_panel_pkg::panel_s panel_in,
  input  wire logic                  lockout_evt,
  output cap_panel_pkg::lamps_s      lamps,
  output logic                       trip_relay,
  output logic                       close_relay,
  output logic      [2:0]            screen_idx
);
  import cap_panel_pkg::*;

  localparam int MS = `MS_CYCLES;   // Cycles per millisecond
  localparam logic [31:0] MS_CYC    = 32'(MS);
  localparam logic [31:0] SHORT_CYC = 32'(`SHORT_PULSE_MS * MS);
  localparam logic [31:0] BLINK_CYC = 32'(`BLINK_MS * MS);
  localparam logic [31:0] FAST_CYC  = 32'(`FAST_BLINK_MS * MS);
  localparam logic [31:0] SCR_CYC   = 32'(`SCREEN_MS * MS);
  localparam logic [31:0] TEST_CYC  = 32'(`LAMP_TEST_MS * MS);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [5:0] s1_ff, s2_ff, s3_ff, clean_ff;
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      clean_ff <= '0;
    end
    else
    begin
      s1_ff <= panel_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 6; i++)
        if (s2_ff[i] == s3_ff[i])
          clean_ff[i] <= s3_ff[i];
    end
  panel_s pin;
  assign pin = clean_ff;
  logic trip_sw_d_ff, close_sw_d_ff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trip_sw_d_ff  <= 1'b0;
      close_sw_d_ff <= 1'b0;
    end
    else
    begin
      trip_sw_d_ff  <= pin.trip_sw;
      close_sw_d_ff <= pin.close_sw;
    end
  logic man_trip, man_close;
  assign man_trip  = !pin.auto_sel && pin.trip_sw && !trip_sw_d_ff;
  assign man_close = !pin.auto_sel && pin.close_sw && !close_sw_d_ff;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [6:0]  ctrl_ff;
  logic [7:0]  dur_ff;
  logic [15:0] trip_dly_ff, close_dly_ff, after_trip_ff;
  logic [31:0] count_ff;
  logic        lockout_ff;
  logic        wr_en;
  assign wr_en = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_ff       <= '0;
      dur_ff        <= `DUR_RESET;
      trip_dly_ff   <= `DLY_RESET;
      close_dly_ff  <= `DLY_RESET;
      after_trip_ff <= `AFTER_TRIP_RST;
    end
    else
    begin
      if (wr_en && paddr == `OFF_CTRL) ctrl_ff <= pwdata[6:0];
      else
      begin
        ctrl_ff[`CTRL_AUTO_TRIP]  <= 1'b0; // Auto commands are one-shot
        ctrl_ff[`CTRL_AUTO_CLOSE] <= 1'b0;
      end
      if (wr_en && paddr == `OFF_DUR)        dur_ff        <= pwdata[7:0];
      if (wr_en && paddr == `OFF_TRIP_DLY)   trip_dly_ff   <= pwdata[15:0];
      if (wr_en && paddr == `OFF_CLOSE_DLY)  close_dly_ff  <= pwdata[15:0];
      if (wr_en && paddr == `OFF_AFTER_TRIP) after_trip_ff <= pwdata[15:0];
    end

  // ****************************************************************
  // Lockout and automatic gating
  // ****************************************************************
  // Lockout holds until reset switch; new event wins over reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) lockout_ff <= 1'b0;
    else if (lockout_evt || ctrl_ff[`CTRL_LOCKOUT]) lockout_ff <= 1'b1;
    else if (pin.reset_sw) lockout_ff <= 1'b0;
  logic auto_ok, req_trip, req_close;
  assign auto_ok   = pin.auto_sel && !lockout_ff;
  assign req_trip  = man_trip || (auto_ok && ctrl_ff[`CTRL_AUTO_TRIP]);
  assign req_close = man_close || (auto_ok && ctrl_ff[`CTRL_AUTO_CLOSE]);

  // ****************************************************************
  // Millisecond tick and timers
  // ****************************************************************
  logic [31:0] ms_cnt_ff;
  logic        ms_tick;
  assign ms_tick = (ms_cnt_ff == MS_CYC - 32'd1);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ms_cnt_ff <= `ZERO32;
    else ms_cnt_ff <= ms_tick ? `ZERO32 : ms_cnt_ff + 32'd1;

  seq_state_e  state_ff;
  logic [31:0] dly_ff;
  logic [35:0] pulse_ff;          // Wide enough for 255 s of cycles
  logic [31:0] after_ff;          // seconds in ms
  logic        tripped_ff;
  logic        last_trip_ff, last_close_ff;
  logic        uv, after_act, close_inh, trip_inh, close_inh_other;
  assign uv        = ctrl_ff[`CTRL_UV_INH];
  assign after_act = after_ff != `ZERO32;
  assign trip_inh  = (state_ff == ST_TRIP_WAIT) || uv;
  assign close_inh = after_act || (state_ff == ST_CLS_WAIT) || uv
                   || ctrl_ff[`CTRL_HUNT_INH] || ctrl_ff[`CTRL_LIMIT_HIT];
  // Inhibits other than the manual close delay itself
  assign close_inh_other = after_act || uv || ctrl_ff[`CTRL_HUNT_INH]
                         || ctrl_ff[`CTRL_LIMIT_HIT];
  logic [35:0] pulse_len;
  assign pulse_len = (dur_ff == `DUR_SHORT_CODE) ? 36'(SHORT_CYC)
                   : 36'(dur_ff) * 36'(`MS_PER_S) * 36'(MS_CYC);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_ff      <= ST_IDLE;
      dly_ff        <= `ZERO32;
      pulse_ff      <= '0;
      after_ff      <= `ZERO32;
      tripped_ff    <= 1'b1;
      last_trip_ff  <= 1'b0;
      last_close_ff <= 1'b0;
      count_ff      <= `ZERO32;
    end
    else
    begin
      if (after_act && ms_tick) after_ff <= after_ff - 32'd1;
      case (state_ff)
        ST_IDLE:
        begin
          if (req_trip)
          begin
            last_trip_ff  <= 1'b1;
            last_close_ff <= 1'b0;
            if (trip_dly_ff != 16'h0000 || uv)
            begin
              dly_ff   <= 32'(trip_dly_ff) * `MS_PER_S;
              state_ff <= ST_TRIP_WAIT;
            end
            else
            begin
              pulse_ff   <= pulse_len;
              after_ff   <= 32'(after_trip_ff) * `MS_PER_S;
              tripped_ff <= 1'b1;
              state_ff   <= ST_TRIP_PULSE;
            end
          end
          else if (req_close && tripped_ff)
          begin
            last_close_ff <= 1'b1;
            last_trip_ff  <= 1'b0;
            dly_ff        <= 32'(close_dly_ff) * `MS_PER_S;
            state_ff      <= ST_CLS_WAIT;
          end
        end
        ST_TRIP_WAIT:
          if (dly_ff != `ZERO32) dly_ff <= ms_tick ? dly_ff - 32'd1 : dly_ff;
          else if (!uv)
          begin
            pulse_ff   <= pulse_len;
            after_ff   <= 32'(after_trip_ff) * `MS_PER_S;
            tripped_ff <= 1'b1;
            state_ff   <= ST_TRIP_PULSE;
          end
        ST_CLS_WAIT:
          if (dly_ff != `ZERO32) dly_ff <= ms_tick ? dly_ff - 32'd1 : dly_ff;
          else if (!close_inh_other)
          begin
            pulse_ff   <= pulse_len;
            tripped_ff <= 1'b0;
            count_ff   <= count_ff + 32'd1;
            state_ff   <= ST_CLS_PULSE;
          end
        ST_TRIP_PULSE, ST_CLS_PULSE:
          if (pulse_ff > 36'd1) pulse_ff <= pulse_ff - 36'd1;
          else
          begin
            pulse_ff <= '0;
            state_ff <= ST_IDLE;
          end
        default: state_ff <= ST_IDLE;
      endcase
    end

  // ****************************************************************
  // Lamp timing
  // ****************************************************************
  logic [31:0] blink_cnt_ff, fast_cnt_ff, scr_cnt_ff, test_cnt_ff;
  logic        blink_ff, fast_ff;
  logic [2:0]  scr_ff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      blink_cnt_ff <= `ZERO32;
      fast_cnt_ff  <= `ZERO32;
      scr_cnt_ff   <= `ZERO32;
      test_cnt_ff  <= `ZERO32;
      blink_ff     <= 1'b0;
      fast_ff      <= 1'b0;
      scr_ff       <= 3'h0;
    end
    else
    begin
      if (blink_cnt_ff == BLINK_CYC - 32'd1)
      begin
        blink_cnt_ff <= `ZERO32;
        blink_ff     <= ~blink_ff;
      end
      else blink_cnt_ff <= blink_cnt_ff + 32'd1;
      if (fast_cnt_ff == FAST_CYC - 32'd1)
      begin
        fast_cnt_ff <= `ZERO32;
        fast_ff     <= ~fast_ff;
      end
      else fast_cnt_ff <= fast_cnt_ff + 32'd1;
      if (scr_cnt_ff == SCR_CYC - 32'd1)
      begin
        scr_cnt_ff <= `ZERO32;
        scr_ff     <= scr_ff + 3'h1;
      end
      else scr_cnt_ff <= scr_cnt_ff + 32'd1;
      if (test_cnt_ff != TEST_CYC) test_cnt_ff <= test_cnt_ff + 32'd1;
    end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic test;
  logic comm;
  assign test = test_cnt_ff != TEST_CYC;
  assign comm = pin.rx_act || pin.tx_act;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lamps       <= '0;
      trip_relay  <= 1'b0;
      close_relay <= 1'b0;
      screen_idx  <= 3'h0;
    end
    else
    begin
      trip_relay  <= state_ff == ST_TRIP_PULSE;
      close_relay <= state_ff == ST_CLS_PULSE;
      screen_idx  <= scr_ff;
      lamps.ac_power  <= 1'b1;
      lamps.cpu_ok    <= test | blink_ff;
      lamps.rev_power <= test | ctrl_ff[`CTRL_REV_PWR];
      lamps.trip_inh  <= test | trip_inh;
      lamps.close_inh <= test | close_inh;
      lamps.lockout   <= test | lockout_ff;
      lamps.trip      <= test | (state_ff == ST_TRIP_WAIT ? blink_ff : last_trip_ff);
      lamps.close     <= test | (state_ff == ST_CLS_WAIT ? blink_ff : last_close_ff);
      lamps.rx        <= pin.rx_act & fast_ff;
      lamps.tx        <= pin.tx_act & fast_ff & comm;
    end

  // ****************************************************************
  // APB read side
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata  <= `ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          `OFF_CTRL:       prdata <= {25'h0, ctrl_ff};
          `OFF_DUR:        prdata <= {24'h0, dur_ff};
          `OFF_TRIP_DLY:   prdata <= {16'h0, trip_dly_ff};
          `OFF_CLOSE_DLY:  prdata <= {16'h0, close_dly_ff};
          `OFF_AFTER_TRIP: prdata <= {16'h0, after_trip_ff};
          `OFF_STATUS:     prdata <= {24'h0, tripped_ff, lockout_ff, close_inh,
                                      trip_inh, 1'b0, state_ff};
          `OFF_COUNT:      prdata <= count_ff;
          default:
          begin
            prdata  <= `ZERO32;
            pslverr <= 1'b1;
          end
        endcase
      end
    end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_NO_OVERLAP: assert property (@(posedge pclk) disable iff (!presetn)
    !(trip_relay && close_relay)) else $error("both relays on");
  AST_CLOSE_INH: assert property (@(posedge pclk) disable iff (!presetn)
    after_act |-> state_ff != ST_CLS_PULSE || $past(state_ff) == ST_CLS_PULSE)
    else $error("close fired during after-trip inhibit");
  AST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_CLS_PULSE && $past(state_ff) == ST_CLS_WAIT)
    |-> count_ff == $past(count_ff) + 32'd1) else $error("counter missed");
  AST_TRIP_RELAY: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_TRIP_PULSE |=> trip_relay) else $error("trip relay late");
  AST_AUTO_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE && !pin.auto_sel && !man_trip && !man_close)
    |=> state_ff == ST_IDLE) else $error("auto ran in manual");
  AST_TRIP_INH: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_TRIP_WAIT && !test) |=> lamps.trip_inh)
    else $error("trip inhibit lamp off");
  AST_CLOSE_LAMP: assert property (@(posedge pclk) disable iff (!presetn)
    (close_inh && !test) |=> lamps.close_inh) else $error("close inhibit lamp off");
  AST_LOCKOUT: assert property (@(posedge pclk) disable iff (!presetn)
    lockout_evt |=> lockout_ff) else $error("lockout not latched");
endmodule : cap_panel_ctrl

// ### verification/cap_switch_model.sv
// Behavioural capacitor bank switch driven by the trip and close relays.
// Assumes relay outputs are registered levels on pclk.
`timescale 1ns/1ps

module cap_switch_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trip_relay,
  input  wire logic close_relay,
  output logic      sw_closed,
  output logic      both_on
);
  // ************************************************************
  // Switch position and relay overlap
  // ************************************************************
  // Switch follows whichever coil is energised, starts open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_closed <= 1'b0;
      both_on   <= 1'b0;
    end
    else
    begin
      if (trip_relay)
        sw_closed <= 1'b0;
      else if (close_relay)
        sw_closed <= 1'b1;
      if (trip_relay && close_relay)
        both_on <= 1'b1; // Sticky overlap flag
    end
  end
endmodule : cap_switch_model

// ### verification/capacitor_switch_panel_control_tb_top.sv
// Testbench of the capacitor panel block: APB tasks and panel switch tests.
// Assumes the design files and the switch model are compiled first.
`timescale 1ns/1ps
`include "cap_panel_regs.svh"

module capacitor_switch_panel_control_tb_top;
  import cap_panel_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic         pclk     = 1'b0;
  logic         presetn  = 1'b0;
  logic         psel     = 1'b0;
  logic         penable  = 1'b0;
  logic         pwrite   = 1'b0;
  logic [11:0]  paddr    = 12'h000;
  logic [31:0]  pwdata   = 32'h0000_0000;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  panel_s       pnl      = '0;
  logic         lockout_evt = 1'b0;
  lamps_s       lamps;
  logic         trip_relay;
  logic         close_relay;
  logic [2:0]   screen_idx;
  logic         sw_closed;
  logic         both_on;
  logic [31:0]  rd;
  logic         err;
  int           failures = 0;
  int           comparisons = 0;

  // Clock at 100 MHz
  always #5 pclk = ~pclk;

  cap_panel_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_in(pnl), .lockout_evt(lockout_evt), .lamps(lamps), .trip_relay(trip_relay),
    .close_relay(close_relay), .screen_idx(screen_idx)
  );

  cap_switch_model sw (
    .pclk(pclk), .presetn(presetn), .trip_relay(trip_relay),
    .close_relay(close_relay), .sw_closed(sw_closed), .both_on(both_on)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  // Verdict and end of run
  task close_out;
  begin
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask : close_out

  // Compare and count
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
  begin
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      $display("mismatch pready expected 1 seen timeout");
      close_out();
    end
  end
  endtask : apb

  // Read and compare data and error flag
  task rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
              input logic exp_err);
  begin
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
    chk({what, "_err"}, {31'h0, exp_err}, {31'h0, err});
  end
  endtask : rd_chk

  // Momentary switch press long enough for the synchroniser
  task press(input logic is_trip);
  begin
    @(posedge pclk);
    if (is_trip) pnl.trip_sw <= 1'b1;
    else pnl.close_sw <= 1'b1;
    repeat (10) @(posedge pclk);
    pnl.trip_sw  <= 1'b0;
    pnl.close_sw <= 1'b0;
  end
  endtask : press

  // Close relay, and trip relay when chk_trip is set, must stay released for n cycles
  task quiet(input string what, input logic chk_trip, input int n);
    logic seen;
  begin
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge pclk);
      if ((chk_trip && trip_relay !== 1'b0) || close_relay !== 1'b0) seen = 1'b1;
    end
    chk(what, 32'h0, {31'h0, seen});
  end
  endtask : quiet

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    int n;
    #15;
    chk("relays_in_reset", 32'h0, {30'h0, trip_relay, close_relay});
    chk("lamps_in_reset", 32'h0, {22'h0, lamps});
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    // Lamp test: all but receive and transmit lit
    chk("lamp_test", {22'h0, 10'b11_1111_1100}, {22'h0, lamps});
    $display("test reset done");

    rd_chk("dur_rst", `OFF_DUR, {24'h0, `DUR_RESET}, 1'b0);
    rd_chk("after_trip_rst", `OFF_AFTER_TRIP, {16'h0, `AFTER_TRIP_RST}, 1'b0);
    rd_chk("trip_dly_rst", `OFF_TRIP_DLY, 32'h0000_0000, 1'b0);
    rd_chk("close_dly_rst", `OFF_CLOSE_DLY, 32'h0000_0000, 1'b0);
    rd_chk("count_rst", `OFF_COUNT, 32'h0000_0000, 1'b0);
    apb(1'b1, `OFF_DUR, 32'h0000_00ff);
    rd_chk("dur_max", `OFF_DUR, 32'h0000_00ff, 1'b0);
    apb(1'b1, `OFF_DUR, {24'h0, `DUR_SHORT_CODE});
    rd_chk("dur_short", `OFF_DUR, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 12'h01c, 32'h0000_0000, 1'b1);
    $display("test registers done");

    // Switch ignored in automatic
    pnl.auto_sel <= 1'b1;
    press(1'b1);
    quiet("trip_in_auto", 1'b1, 100);
    // Automatic command suspended in manual
    pnl.auto_sel <= 1'b0;
    repeat (6) @(posedge pclk); // Let the selector pass the synchroniser
    apb(1'b1, `OFF_CTRL, 32'h0000_0001);
    apb(1'b1, `OFF_CTRL, 32'h0000_0000);
    quiet("auto_trip_in_manual", 1'b1, 100);
    $display("test selector done");

    // Manual trip energises the trip relay only
    press(1'b1);
    n = 0;
    while (trip_relay !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    chk("trip_relay", 32'h1, {31'h0, trip_relay});
    chk("close_relay_off", 32'h0, {31'h0, close_relay});
    @(posedge pclk);
    chk("switch_open", 32'h0, {31'h0, sw_closed});
    // Close refused while the trip pulse is still on
    press(1'b0);
    quiet("close_during_trip", 1'b0, 200);
    chk("trip_still_on", 32'h1, {31'h0, trip_relay});
    rd_chk("count_no_close", `OFF_COUNT, 32'h0000_0000, 1'b0);
    chk("no_overlap", 32'h0, {31'h0, both_on});
    chk("screen_idx", 32'h0, {29'h0, screen_idx});
    $display("test manual trip done");
    // Lockout latches until the reset switch; status during the trip pulse
    lockout_evt <= 1'b1;
    @(posedge pclk);
    lockout_evt <= 1'b0;
    rd_chk("status_lockout", `OFF_STATUS, 32'h0000_00e2, 1'b0);
    pnl.reset_sw <= 1'b1;
    repeat (6) @(posedge pclk);
    pnl.reset_sw <= 1'b0;
    rd_chk("status_released", `OFF_STATUS, 32'h0000_00a2, 1'b0);
    $display("test lockout done");
    close_out();
  end
endmodule : capacitor_switch_panel_control_tb_top
